/* File: common/pol_pkg.sv */
package pol_pkg;

    // object indices on the object access port
    localparam logic [15:0] IDX_CONTROL   = 16'h6040;
    localparam logic [15:0] IDX_STATUS    = 16'h6041;
    localparam logic [15:0] IDX_TARGET    = 16'h607A;
    localparam logic [15:0] IDX_OPTIONS   = 16'h60F2;
    localparam logic [15:0] IDX_FOLLOW    = 16'h60F4;

    // option word layout
    localparam logic [15:0] OPTIONS_RESET = 16'h0001;
    localparam logic [15:0] OPTIONS_MASK  = 16'h8FFF;
    localparam int          REF_LSB       = 0;
    localparam int          CHANGE_LSB    = 2;
    localparam int          RELEASE_LSB   = 4;
    localparam int          DIR_LSB       = 6;
    localparam int          IPO_LSB       = 8;
    localparam int          MAKER_BIT     = 15;

    // control and status word bits
    localparam int          CW_NEW_SP_BIT   = 4;
    localparam int          CW_RELATIVE_BIT = 6;
    localparam int          SW_REACHED_BIT  = 10;
    localparam int          SW_ACK_BIT      = 12;

    localparam logic [15:0] ZERO16 = 16'h0000;
    // signed so position compares against it stay signed
    localparam logic signed [31:0] ZERO32 = 32'sh0000_0000;

    typedef enum logic [1:0] {
        REF_PREV_TARGET,
        REF_RAMP_OUTPUT,
        REF_ACTUAL_POS,
        REF_RESERVED
    } pol_ref_type;

    typedef enum logic [1:0] {
        REL_BY_HOST,
        REL_ON_REACHED,
        REL_EARLIEST,
        REL_RESERVED
    } pol_release_type;

    typedef enum logic [1:0] {
        DIR_LINEAR,
        DIR_NEG_ONLY,
        DIR_POS_ONLY,
        DIR_SHORTEST
    } pol_dir_type;

    typedef enum logic [1:0] {
        SP_IDLE,
        SP_HELD
    } pol_sp_state_type;

endpackage

/* File: common/pol_move_if.sv */
`timescale 1ns/100ps
interface pol_move_if;
    import pol_pkg::*;
    pol_ref_type        ref_sel;
    pol_dir_type        dir_sel;
    logic               relative;
    logic signed [31:0] new_target;
    logic signed [31:0] prev_target;
    logic               prev_valid;
    logic signed [31:0] ramp_pos;
    logic signed [31:0] actual_pos;
    logic signed [31:0] range_min;
    logic signed [31:0] range_max;
    logic signed [31:0] raw_target;
    logic signed [31:0] wrapped_target;
    logic signed [31:0] distance;
    logic               positive;

    modport ctrl (output ref_sel, dir_sel, relative, new_target,
                  prev_target, prev_valid, ramp_pos, actual_pos,
                  range_min, range_max,
                  input  wrapped_target, distance, positive);
    modport calc (input  ref_sel, relative, new_target, prev_target,
                  prev_valid, ramp_pos, actual_pos, range_min, range_max,
                  output raw_target, wrapped_target);
    modport dir  (input  dir_sel, raw_target, wrapped_target, actual_pos,
                  range_min, range_max,
                  output distance, positive);
endinterface

/* File: rtl/pol_target_calc.sv */
`timescale 1ns/100ps
module pol_target_calc
    import pol_pkg::*;
(
    pol_move_if.calc mv
);
    logic signed [31:0] base;
    logic signed [31:0] span;

    always_comb begin
        base = ZERO32;
        if (mv.relative) begin
            case (mv.ref_sel)
                REF_PREV_TARGET: begin
                    base = mv.prev_valid ? mv.prev_target : ZERO32;
                end
                REF_RAMP_OUTPUT: begin
                    base = mv.ramp_pos;
                end
                REF_ACTUAL_POS: begin
                    base = mv.actual_pos;
                end
                default: begin
                    // reserved code: fall back to the previous target
                    base = mv.prev_valid ? mv.prev_target : ZERO32;
                end
            endcase
        end
        mv.raw_target = 32'(base + mv.new_target);
        span = 32'(mv.range_max - mv.range_min);
        // passing either limit lands the setpoint on the other side
        if (span == ZERO32) begin
            mv.wrapped_target = mv.raw_target;
        end else if (mv.raw_target >= mv.range_max) begin
            mv.wrapped_target = 32'(mv.raw_target - span);
        end else if (mv.raw_target < mv.range_min) begin
            mv.wrapped_target = 32'(mv.raw_target + span);
        end else begin
            mv.wrapped_target = mv.raw_target;
        end
    end

endmodule // pol_target_calc

/* File: rtl/pol_rotary_dir.sv */
`timescale 1ns/100ps
module pol_rotary_dir
    import pol_pkg::*;
(
    pol_move_if.dir mv
);
    logic signed [31:0] span;
    logic signed [31:0] diff;
    logic signed [31:0] fwd;

    always_comb begin
        span = 32'(mv.range_max - mv.range_min);
        diff = 32'(mv.wrapped_target - mv.actual_pos);
        // forward distance folded into one turn
        fwd  = (diff < ZERO32) ? 32'(diff + span) : diff;
        case (mv.dir_sel)
            DIR_LINEAR: begin
                // only here may a move exceed one modulo turn
                mv.distance = 32'(mv.raw_target - mv.actual_pos);
            end
            DIR_NEG_ONLY: begin
                mv.distance = (diff > ZERO32) ? 32'(diff - span)
                                              : diff;
            end
            DIR_POS_ONLY: begin
                mv.distance = (diff < ZERO32) ? 32'(diff + span)
                                              : diff;
            end
            default: begin
                // half a turn decides the direction
                mv.distance = (fwd < 32'(span >>> 1)) ? fwd
                                                     : 32'(fwd - span);
            end
        endcase
        mv.positive = !mv.distance[31];
    end

endmodule // pol_rotary_dir

/* File: rtl/pol_option_logic.sv */
// Overview of operation
// - relative option only when control bit 6 set
// - code 00 adds previous target or zero
// - code 01 adds ramp generator output
// - code 10 adds actual position, 11 reserved
// - self-release lets device clear new-setpoint bit
// - device clear also drops setpoint acknowledge
// - device writes control word during self-release
// - release code 00 keeps host-cleared handshake
// - release code 01 clears when target reached
// - release code 10 clears at earliest moment
// - linear policy wraps setpoint at range limits
// - over-modulo moves only with linear policy
// - policy 01 moves negative only, wraps minimum
// - policy 10 moves positive only, wraps maximum
// - policy 11 takes shortest path, under half
// - sixteen-bit option word, unsupported bits reserved
// - following error read-only signed 32-bit value
`timescale 1ns/100ps
module pol_option_logic
    import pol_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ce_in,
    // object access port
    input  wire logic [15:0] obj_index_in,
    input  wire logic        obj_wr_in,
    input  wire logic        obj_rd_in,
    input  wire logic [31:0] obj_wdata_in,
    output logic      [31:0] obj_rdata_out,
    output logic             obj_ack_out,
    output logic             obj_err_out,
    // motion core side
    input  wire logic [31:0] ramp_pos_in,
    input  wire logic [31:0] actual_pos_in,
    input  wire logic [31:0] range_min_in,
    input  wire logic [31:0] range_max_in,
    input  wire logic [31:0] following_error_in,
    input  wire logic        target_reached_in,
    output logic             move_start_out,
    output logic      [31:0] move_target_out,
    output logic      [31:0] move_distance_out,
    output logic             move_positive_out,
    output logic      [15:0] control_word_out,
    output logic             setpoint_ack_out
);

    // every option field used here is two bits wide
    function automatic logic [1:0] field2(input logic [15:0] w,
                                          input int lsb);
        field2 = w[lsb +: 2];
    endfunction

    // wrap and direction math sit in two helpers on one bus
    pol_move_if mv ();

    pol_target_calc u_calc (
        .mv (mv.calc)
    );

    pol_rotary_dir u_dir (
        .mv (mv.dir)
    );

    // registered state
    logic [15:0]        options;
    logic [15:0]        control_word;
    logic signed [31:0] target_value;
    logic signed [31:0] prev_target;
    logic               prev_valid;
    logic               new_sp_prev;
    logic               move_active;
    logic               ack;
    pol_sp_state_type   sp_state;
    logic [31:0]        rdata;
    logic               bus_ack;
    logic               bus_err;
    logic               start;
    logic signed [31:0] move_target;
    logic signed [31:0] move_distance;
    logic               move_positive;

    logic [15:0]        next_options;
    logic [15:0]        next_control_word;
    logic signed [31:0] next_target_value;
    logic signed [31:0] next_prev_target;
    logic               next_prev_valid;
    logic               next_new_sp_prev;
    logic               next_move_active;
    logic               next_ack;
    pol_sp_state_type   next_sp_state;
    logic [31:0]        next_rdata;
    logic               next_bus_ack;
    logic               next_bus_err;
    logic               next_start;
    logic signed [31:0] next_move_target;
    logic signed [31:0] next_move_distance;
    logic               next_move_positive;

    // combinational helpers, not registered
    logic               sp_rise;
    logic               dev_clear;
    logic               host_wr_cw;
    pol_release_type    release_mode;

    // feed the target path
    always_comb begin
        mv.ref_sel     = pol_ref_type'(field2(options, REF_LSB));
        mv.dir_sel     = pol_dir_type'(field2(options, DIR_LSB));
        // absolute moves ignore the reference field entirely
        mv.relative    = control_word[CW_RELATIVE_BIT];
        mv.new_target  = target_value;
        mv.prev_target = prev_target;
        mv.prev_valid  = prev_valid;
        mv.ramp_pos    = ramp_pos_in;
        mv.actual_pos  = actual_pos_in;
        mv.range_min   = range_min_in;
        mv.range_max   = range_max_in;
    end

    // register access
    always_comb begin
        next_options      = options;
        next_target_value = target_value;
        next_rdata        = rdata;
        next_bus_ack      = 1'b0;
        next_bus_err      = 1'b0;
        host_wr_cw        = 1'b0;
        if (obj_wr_in) begin
            next_bus_ack = 1'b1;
            case (obj_index_in)
                IDX_OPTIONS: begin
                    // unsupported bits are dropped
                    next_options = obj_wdata_in[15:0] & OPTIONS_MASK;
                end
                IDX_CONTROL: begin
                    host_wr_cw = 1'b1;
                end
                IDX_TARGET: begin
                    next_target_value = obj_wdata_in;
                end
                default: begin
                    // status and following error are read-only
                    next_bus_err = 1'b1;
                end
            endcase
        end else if (obj_rd_in) begin
            next_bus_ack = 1'b1;
            case (obj_index_in)
                IDX_OPTIONS: begin
                    next_rdata = {ZERO16, options};
                end
                IDX_CONTROL: begin
                    next_rdata = {ZERO16, control_word};
                end
                IDX_STATUS: begin
                    // bit 10 stands while no move is in progress
                    next_rdata = ZERO32;
                    next_rdata[SW_ACK_BIT] = ack;
                    next_rdata[SW_REACHED_BIT] = !move_active;
                end
                IDX_TARGET: begin
                    next_rdata = target_value;
                end
                IDX_FOLLOW: begin
                    next_rdata = following_error_in;
                end
                default: begin
                    // unmapped index reads as zero
                    next_rdata   = ZERO32;
                    next_bus_err = 1'b1;
                end
            endcase
        end
    end

    // setpoint handshake
    always_comb begin
        release_mode       = pol_release_type'(field2(options, RELEASE_LSB));
        sp_rise            = control_word[CW_NEW_SP_BIT] && !new_sp_prev;
        dev_clear          = 1'b0;
        next_sp_state      = sp_state;
        next_ack           = ack;
        next_start         = 1'b0;
        next_move_active   = move_active;
        next_prev_target   = prev_target;
        next_prev_valid    = prev_valid;
        next_move_target   = move_target;
        next_move_distance = move_distance;
        next_move_positive = move_positive;
        // reached ends the move even with no release pending
        if (move_active && target_reached_in) begin
            next_move_active = 1'b0;
        end
        case (sp_state)
            SP_IDLE: begin
                // only an idle handshake takes a new setpoint
                if (sp_rise) begin
                    next_ack           = 1'b1;
                    next_start         = 1'b1;
                    next_move_active   = 1'b1;
                    next_move_target   = mv.wrapped_target;
                    next_move_distance = mv.distance;
                    next_move_positive = mv.positive;
                    next_prev_target   = mv.wrapped_target;
                    next_prev_valid    = 1'b1;
                    next_sp_state      = SP_HELD;
                end
            end
            SP_HELD: begin
                case (release_mode)
                    REL_ON_REACHED: begin
                        dev_clear = move_active
                                    && target_reached_in;
                    end
                    REL_EARLIEST: begin
                        dev_clear = 1'b1;
                    end
                    default: begin
                        // host drops the bit itself
                        if (!control_word[CW_NEW_SP_BIT]) begin
                            next_ack      = 1'b0;
                            next_sp_state = SP_IDLE;
                        end
                    end
                endcase
                if (dev_clear) begin
                    next_ack      = 1'b0;
                    next_sp_state = SP_IDLE;
                end
            end
            default: begin
                next_sp_state = SP_IDLE;
            end
        endcase
    end

    // control word: host write wins over device release
    always_comb begin
        next_control_word = control_word;
        if (dev_clear) begin
            next_control_word[CW_NEW_SP_BIT] = 1'b0;
        end
        // a host write replaces the whole word, bit 4 included
        if (host_wr_cw) begin
            next_control_word = obj_wdata_in[15:0];
        end
        // a device clear counts as a fall so the next set is seen
        next_new_sp_prev = dev_clear ? 1'b0
                                     : control_word[CW_NEW_SP_BIT];
    end

    // reset outranks ce so a frozen block can still be cleared
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            options       <= OPTIONS_RESET;
            control_word  <= ZERO16;
            target_value  <= ZERO32;
            prev_target   <= ZERO32;
            prev_valid    <= 1'b0;
            new_sp_prev   <= 1'b0;
            move_active   <= 1'b0;
            ack           <= 1'b0;
            sp_state      <= SP_IDLE;
            rdata         <= ZERO32;
            bus_ack       <= 1'b0;
            bus_err       <= 1'b0;
            start         <= 1'b0;
            move_target   <= ZERO32;
            move_distance <= ZERO32;
            move_positive <= 1'b1;
        end else if (ce_in) begin
            options       <= next_options;
            control_word  <= next_control_word;
            target_value  <= next_target_value;
            prev_target   <= next_prev_target;
            prev_valid    <= next_prev_valid;
            new_sp_prev   <= next_new_sp_prev;
            move_active   <= next_move_active;
            ack           <= next_ack;
            sp_state      <= next_sp_state;
            rdata         <= next_rdata;
            bus_ack       <= next_bus_ack;
            bus_err       <= next_bus_err;
            start         <= next_start;
            move_target   <= next_move_target;
            move_distance <= next_move_distance;
            move_positive <= next_move_positive;
        end
    end

    // outputs straight from flops, no decode behind them
    assign obj_rdata_out     = rdata;
    assign obj_ack_out       = bus_ack;
    assign obj_err_out       = bus_err;
    assign move_start_out    = start;
    assign move_target_out   = move_target;
    assign move_distance_out = move_distance;
    assign move_positive_out = move_positive;
    assign control_word_out  = control_word;
    assign setpoint_ack_out  = ack;

endmodule // pol_option_logic

/* File: tb/pol_option_logic_checker.sv */
`timescale 1ns/100ps
module pol_option_logic_checker
    import pol_pkg::*;
(
    input wire logic        core_clk_in, sys_rst_in, ce_in,
    input wire logic [15:0] obj_index_in,
    input wire logic        obj_wr_in, obj_rd_in,
    input wire logic [31:0] obj_wdata_in, obj_rdata_out,
    input wire logic        obj_ack_out, obj_err_out,
    input wire logic [31:0] ramp_pos_in, actual_pos_in,
    input wire logic [31:0] range_min_in, range_max_in, following_error_in,
    input wire logic        target_reached_in, move_start_out,
    input wire logic [31:0] move_target_out, move_distance_out,
    input wire logic        move_positive_out,
    input wire logic [15:0] control_word_out,
    input wire logic        setpoint_ack_out
);
    // shadow of the option word, so modes can qualify the checks
    logic [15:0] opt;
    logic [15:0] next_opt;
    logic        cw_wr;
    assign cw_wr = obj_wr_in && obj_index_in == IDX_CONTROL;
    always_comb begin
        next_opt = opt;
        if (ce_in && obj_wr_in && obj_index_in == IDX_OPTIONS) begin
            next_opt = obj_wdata_in[15:0] & OPTIONS_MASK;
        end
    end
    always_ff @(posedge core_clk_in) begin
        opt <= sys_rst_in ? OPTIONS_RESET : next_opt;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    ack_latency_a: assert property (ce_in && (obj_wr_in || obj_rd_in) |=> obj_ack_out)
        else $error("access not answered one cycle later");
    ack_idle_a: assert property (ce_in && !obj_wr_in && !obj_rd_in |=> !obj_ack_out && !obj_err_out)
        else $error("answer without an access");
    ro_refuse_a: assert property (ce_in && obj_wr_in && obj_index_in == IDX_FOLLOW |=> obj_ack_out && obj_err_out)
        else $error("write to read-only following error accepted");
    follow_read_a: assert property (ce_in && obj_rd_in && !obj_wr_in && obj_index_in == IDX_FOLLOW |=> !obj_err_out && obj_rdata_out == $past(following_error_in))
        else $error("following error read wrong");
    start_ack_a: assert property (move_start_out |-> setpoint_ack_out ##1 !move_start_out)
        else $error("start without acknowledge or longer than a cycle");
    host_hold_a: assert property (opt[5:4] == 2'b00 && setpoint_ack_out && control_word_out[4] |=> setpoint_ack_out)
        else $error("acknowledge dropped while host holds new setpoint");
    reached_rel_a: assert property (opt[5:4] == 2'b01 && setpoint_ack_out && target_reached_in && !cw_wr |=> !setpoint_ack_out && !control_word_out[4])
        else $error("no release after target reached");
    earliest_rel_a: assert property (opt[5:4] == 2'b10 && $rose(setpoint_ack_out) && !cw_wr |=> !setpoint_ack_out && !control_word_out[4])
        else $error("no early release");
    neg_only_a: assert property (move_start_out && opt[7:6] == 2'b01 |-> $signed(move_distance_out) <= 0)
        else $error("positive travel in negative-only policy");
    pos_only_a: assert property (move_start_out && opt[7:6] == 2'b10 |-> $signed(move_distance_out) >= 0 && move_positive_out)
        else $error("negative travel in positive-only policy");
    dir_sign_a: assert property (move_positive_out == !move_distance_out[31])
        else $error("direction flag disagrees with distance");

    cover property (move_start_out && opt[7:6] == 2'b11);
    cover property ($fell(setpoint_ack_out) && opt[5:4] == 2'b01);
    cover property (obj_ack_out && obj_err_out);
endmodule // pol_option_logic_checker

bind pol_option_logic pol_option_logic_checker u_chk (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .obj_index_in(obj_index_in), .obj_wr_in(obj_wr_in),
    .obj_rd_in(obj_rd_in), .obj_wdata_in(obj_wdata_in),
    .obj_rdata_out(obj_rdata_out), .obj_ack_out(obj_ack_out),
    .obj_err_out(obj_err_out), .ramp_pos_in(ramp_pos_in),
    .actual_pos_in(actual_pos_in), .range_min_in(range_min_in),
    .range_max_in(range_max_in), .following_error_in(following_error_in),
    .target_reached_in(target_reached_in),
    .move_start_out(move_start_out), .move_target_out(move_target_out),
    .move_distance_out(move_distance_out),
    .move_positive_out(move_positive_out),
    .control_word_out(control_word_out),
    .setpoint_ack_out(setpoint_ack_out));

/* File: tb/pol_host_model.sv */
`timescale 1ns/100ps
module pol_host_model (
    input  wire logic        core_clk_in,
    input  wire logic [31:0] obj_rdata_in,
    input  wire logic        obj_ack_in,
    input  wire logic        obj_err_in,
    output logic      [15:0] obj_index_out,
    output logic             obj_wr_out,
    output logic             obj_rd_out,
    output logic      [31:0] obj_wdata_out
);
    initial begin
        obj_index_out = 16'h0000;
        obj_wr_out    = 1'b0;
        obj_rd_out    = 1'b0;
        obj_wdata_out = 32'h0000_0000;
    end
    // one-cycle strobe; the answer is due exactly one cycle later
    task automatic access(input logic w, input logic [15:0] idx,
                          input logic [31:0] wd, output logic [31:0] rd,
                          output logic er, output logic ok);
        @(negedge core_clk_in);
        obj_index_out = idx;
        obj_wdata_out = wd;
        obj_wr_out    = w;
        obj_rd_out    = !w;
        @(negedge core_clk_in);
        obj_wr_out    = 1'b0;
        obj_rd_out    = 1'b0;
        // released lines carry junk so stale values cannot pass
        obj_index_out = ~idx;
        obj_wdata_out = ~wd;
        ok = obj_ack_in;
        er = obj_err_in;
        rd = obj_rdata_in;
    endtask
endmodule // pol_host_model

/* File: tb/pol_option_logic_tb.sv */
`timescale 1ns/100ps
module pol_option_logic_tb;
    import pol_pkg::*;
    localparam logic signed [31:0] RMIN = 32'shFFFF_F830;
    localparam logic signed [31:0] RMAX = 32'sh0000_07D0;
    localparam logic signed [31:0] SPAN = 32'sh0000_0FA0;
    logic        clk, rst, ce, wr, rd, ack, err, reached, start, mpos, sack;
    logic [15:0] idx, cw;
    logic [31:0] wdata, rdata, ramp, act, rmin, rmax, ferr, mtgt, mdist;
    logic [31:0] r;
    logic        e0, ok0;
    logic signed [31:0] prev;
    int          n_fail = 0, checked = 0, cyc = 0;

    pol_host_model host (.core_clk_in(clk), .obj_rdata_in(rdata),
        .obj_ack_in(ack), .obj_err_in(err), .obj_index_out(idx),
        .obj_wr_out(wr), .obj_rd_out(rd), .obj_wdata_out(wdata));
    pol_option_logic dut (.core_clk_in(clk), .sys_rst_in(rst), .ce_in(ce),
        .obj_index_in(idx), .obj_wr_in(wr), .obj_rd_in(rd),
        .obj_wdata_in(wdata), .obj_rdata_out(rdata), .obj_ack_out(ack),
        .obj_err_out(err), .ramp_pos_in(ramp), .actual_pos_in(act),
        .range_min_in(rmin), .range_max_in(rmax),
        .following_error_in(ferr), .target_reached_in(reached),
        .move_start_out(start), .move_target_out(mtgt),
        .move_distance_out(mdist), .move_positive_out(mpos),
        .control_word_out(cw), .setpoint_ack_out(sack));

    always #2.5 clk = ~clk;

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] i,
                       input logic [31:0] d, input logic ee);
        logic e, ok;
        host.access(w, i, d, r, e, ok);
        chk_bit(ok, 1'b1);
        chk_bit(e, ee);
    endtask
    function automatic logic signed [31:0] wrap(input logic signed [31:0] v);
        if (v >= RMAX) wrap = v - SPAN;
        else if (v < RMIN) wrap = v + SPAN;
        else wrap = v;
    endfunction
    function automatic logic [31:0] exp_dist(input logic [1:0] d,
        input logic signed [31:0] raw, input logic signed [31:0] w,
        input logic signed [31:0] a);
        logic signed [31:0] f;
        f = w - a;
        case (d)
            2'b00: exp_dist = raw - a;
            2'b01: exp_dist = (f > 0) ? f - SPAN : f;
            2'b10: exp_dist = (f < 0) ? f + SPAN : f;
            default: begin
                if (f < 0) f = f + SPAN;
                exp_dist = (f < SPAN / 2) ? f : f - SPAN;
            end
        endcase
    endfunction
    function automatic logic [31:0] rnd(input int lim);
        rnd = $urandom_range(2 * lim) - lim;
    endfunction

    task automatic move(input logic [1:0] rf, input logic [1:0] rls,
        input logic [1:0] dpol, input logic rel, input logic signed [31:0] t);
        logic signed [31:0] raw, exp_t;
        logic [31:0] ed;
        raw = t + (!rel ? 32'sh0 : rf == 2'b00 ? prev
              : rf == 2'b01 ? $signed(ramp) : $signed(act));
        exp_t = wrap(raw);
        ed = exp_dist(dpol, raw, exp_t, act);
        bus(1'b1, IDX_OPTIONS, {24'h00_0000, dpol, rls, 2'b00, rf}, 1'b0);
        bus(1'b1, IDX_TARGET, t, 1'b0);
        bus(1'b1, IDX_CONTROL, {16'h0000, 9'h000, rel, 6'h10}, 1'b0);
        @(negedge clk);
        chk_bit(start, 1'b1);
        chk_word(mtgt, exp_t);
        chk_word(mdist, ed);
        chk_bit(mpos, !ed[31]);
        repeat (2) @(negedge clk);
        chk_bit(sack, rls != 2'b10);
        chk_bit(cw[CW_NEW_SP_BIT], rls != 2'b10);
        bus(1'b0, IDX_STATUS, 32'h0000_0000, 1'b0);
        chk_word(r, {19'h0_0000, rls != 2'b10, 12'h000});
        if (rls == 2'b00) bus(1'b1, IDX_CONTROL, 32'h0000_0000, 1'b0);
        reached = 1'b1;
        @(negedge clk);
        reached = 1'b0;
        @(negedge clk);
        chk_bit(sack, 1'b0);
        chk_bit(cw[CW_NEW_SP_BIT], 1'b0);
        bus(1'b0, IDX_STATUS, 32'h0000_0000, 1'b0);
        chk_word(r, 32'h0000_0400);
        prev = exp_t;
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        reached = 1'b0;
        ramp = 32'h0000_0000;
        act = 32'h0000_0000;
        rmin = RMIN;
        rmax = RMAX;
        ferr = 32'h0000_0000;
        prev = 32'sh0;
        r = 32'h0000_0000;
        void'($urandom(32'h0705));
        repeat (6) @(negedge clk);
        rst = 1'b0;
        ferr = $urandom;
        bus(1'b0, IDX_OPTIONS, 32'h0000_0000, 1'b0);
        chk_word(r, {16'h0000, OPTIONS_RESET});
        bus(1'b0, IDX_FOLLOW, 32'h0000_0000, 1'b0);
        chk_word(r, ferr);
        bus(1'b1, IDX_FOLLOW, 32'h1234_5678, 1'b1);
        bus(1'b0, IDX_FOLLOW, 32'h0000_0000, 1'b0);
        chk_word(r, ferr);
        bus(1'b0, 16'h60F3, 32'h0000_0000, 1'b1);
        chk_word(r, 32'h0000_0000);
        bus(1'b1, IDX_OPTIONS, 32'hFFFF_F6AA, 1'b0);
        bus(1'b0, IDX_OPTIONS, 32'h0000_0000, 1'b0);
        chk_word(r, {16'h0000, 16'hF6AA & OPTIONS_MASK});
        @(negedge clk);
        ce = 1'b0;
        host.access(1'b1, IDX_OPTIONS, 32'h0000_0011, r, e0, ok0);
        chk_bit(ok0, 1'b0);
        ce = 1'b1;
        bus(1'b0, IDX_OPTIONS, 32'h0000_0000, 1'b0);
        chk_word(r, {16'h0000, 16'hF6AA & OPTIONS_MASK});
        move(2'b01, 2'b10, 2'b11, 1'b0, RMAX);
        for (int i = 0; i < 18; i++) begin
            ramp = rnd(500);
            act = rnd(500);
            move(2'(i % 3), 2'((i / 3) % 3), 2'(i % 4), i % 5 != 4,
                 rnd(1500));
        end
        final_report();
    end
endmodule // pol_option_logic_tb
